/* File: sxf_cfg.svh */
// register offsets, field positions and reset values of the transfer format and
// correction control registers; assumes an 8-bit register port with 5-bit address
`ifndef SXF_CFG_SVH
`define SXF_CFG_SVH

`define SXF_ADDR_W        5
`define SXF_OPT_ADDR      5'h15
`define SXF_COR_ADDR      5'h16
`define SXF_LIMIT_ADDR    5'h1C
`define SXF_STAT_ADDR     5'h1D
`define SXF_OPT_RESET     8'h00
`define SXF_COR_RESET     8'h00
// host_transfer_options fields
`define SXF_BLK_SEND      7
`define SXF_BLK_SRC       6
`define SXF_BYT_SEND      5
`define SXF_BYT_SRC       4
`define SXF_SUB_BUF       3
`define SXF_SUB_ALL       2
`define SXF_SUB_STS       1
`define SXF_ZERO_PAD      0
// correction_control fields
`define SXF_AUTO_DISC     7
`define SXF_MODE_SEL      6
`define SXF_FORM_SEL      5
`define SXF_AUTO_TGT      4
`define SXF_F2_CHECK      3
`define SXF_MODE_TOL      2
`define SXF_LIMIT_EN      1
`define SXF_AUTO_RENEW    0
`define SXF_PAD_COUNT     3'h5

`endif

/* File: sxf_pkg.sv */
// types of the transfer format and correction control block
// assumes nothing beyond the config header
package sxf_pkg;
	typedef enum logic [2:0] {
		SXF_CMD_OTHER    = 3'h1,
		SXF_CMD_AREA     = 3'h2,
		SXF_CMD_SUBCODE  = 3'h4
	} sxf_cmd_t;

	typedef enum logic [2:0] {
		SXF_M1     = 3'h1,
		SXF_M2F1   = 3'h2,
		SXF_M2F2   = 3'h4
	} sxf_form_t;
endpackage : sxf_pkg

/* File: sxf_limit_guard.sv */
// drive limit watcher: raises overrun, which sxf_ctl copies to buffer_write_block
// assumes strobes synchronous to core_clk
`include "sxf_cfg.svh"
module sxf_limit_guard #(
	parameter int AREA_W = 9
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// control
	input  wire logic              limit_enable,
	input  wire sxf_pkg::sxf_cmd_t cmd_class,
	input  wire logic              clear_overrun,
	// buffering progress
	input  wire logic              area_done,
	input  wire logic [AREA_W-1:0] area_done_id,
	input  wire logic              subcode_write,
	input  wire logic              subcode_at_limit,
	input  wire logic [AREA_W-1:0] limit_area,
	// status
	output logic                   overrun_reg
);
	logic overrun_next;

	// parameter range check at elaboration
	if (AREA_W < 1 || AREA_W > 16) begin : g_bad_area_w
		$error("AREA_W out of range");
	end

	always_comb begin
		overrun_next = overrun_reg;
		if (clear_overrun) begin
			overrun_next = 1'b0;
		end
		if (limit_enable) begin
			if (cmd_class == sxf_pkg::SXF_CMD_AREA && area_done
				&& area_done_id == limit_area) begin
				overrun_next = 1'b1;
			end
			if (cmd_class == sxf_pkg::SXF_CMD_SUBCODE && subcode_write
				&& subcode_at_limit) begin
				overrun_next = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			overrun_reg <= 1'b0;
		end else begin
			overrun_reg <= overrun_next;
		end
	end
endmodule : sxf_limit_guard

/* File: sxf_ctl.sv */
// transfer format and correction control registers with their decoded controls
// assumes the sub CPU port is synchronous to core_clk, read data one cycle later
//
// Operation
// - subcode status byte sent only when subcode buffering and status enable set
// - five zero bytes after Q flag when buffering, status and pad set and auto transfer enabled
// - automatic discrimination takes mode and form from disc, else select bits
// - manual select: 00 mode1, 10 mode2 form1, 11 mode2 form2
// - auto target bit makes device issue target found and advance in area commands
// - form2 check enable off skips check on form2 sectors and holds failure flag low
// - tolerance clear flags nonzero upper six bits of mode byte
// - limit enabled in area commands: overrun after limit area buffered, writes stop
// - limit enabled in subcode command: overrun at subcode limit address, writes stop
// - limit enable clear ignores both limits, raises no new overrun
// - auto renewal moves limit area to each sector just sent
// - failure flag shows check error in current sector
`include "sxf_cfg.svh"
module sxf_ctl #(
	parameter int AREA_W = 9
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	// register port
	input  wire logic [`SXF_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	// decoder context
	input  wire sxf_pkg::sxf_cmd_t     cmd_class,
	input  wire logic                  auto_transfer_enable,
	input  wire logic [7:0]            disc_mode_byte,
	input  wire logic                  disc_form_bit,
	input  wire logic                  sector_start,
	input  wire logic                  sector_is_form2,
	input  wire logic                  check_error,
	input  wire logic                  target_match,
	// buffering progress
	input  wire logic                  area_done,
	input  wire logic [AREA_W-1:0]     area_done_id,
	input  wire logic                  subcode_write,
	input  wire logic                  subcode_at_limit,
	input  wire logic                  host_sector_done,
	input  wire logic [AREA_W-1:0]     host_sector_area,
	// decoded transfer controls
	output logic                       send_block_flag,
	output logic                       block_flag_from_cpu,
	output logic                       send_byte_flag,
	output logic                       byte_flag_from_cpu,
	output logic                       send_subcode,
	output logic                       send_all_subcode,
	output logic                       send_subcode_status,
	output logic                       send_zero_pad,
	output logic [2:0]                 zero_pad_count,
	// decoded correction controls
	output sxf_pkg::sxf_form_t         correction_form,
	output logic                       mode_byte_error,
	output logic                       check_failure_flag,
	output logic                       target_found,
	output logic                       target_advance,
	output logic                       drive_overrun_status,
	output logic                       buffer_write_block,
	output logic [AREA_W-1:0]          drive_limit_area_ptr
);
	logic [7:0]         opt_reg, opt_next;
	logic [7:0]         cor_reg, cor_next;
	logic [AREA_W-1:0]  area_reg, area_next;
	logic [7:0]         rdata_next;
	logic               overrun;
	logic               clear_overrun;
	logic               s_blk;
	logic               s_blk_src;
	logic               s_byt;
	logic               s_byt_src;
	logic               s_sub;
	logic               s_all;
	logic               s_sts;
	logic               s_pad;
	sxf_pkg::sxf_form_t form_next;
	logic               mderr_next;
	logic               fail_next;
	logic               tf_next;
	logic               ta_next;
	logic               opt_hit;
	logic               cor_hit;
	logic               lim_hit;

	// parameter range check at elaboration
	if (AREA_W < 1 || AREA_W > 16) begin : g_bad_area_w
		$error("AREA_W must be 1 to 16");
	end

	// register address decode
	always_comb begin
		opt_hit = reg_wr && reg_addr == `SXF_OPT_ADDR;
		cor_hit = reg_wr && reg_addr == `SXF_COR_ADDR;
		lim_hit = reg_wr && reg_addr == `SXF_LIMIT_ADDR;
	end

	// register writes, limit pointer
	always_comb begin
		opt_next      = opt_reg;
		cor_next      = cor_reg;
		area_next     = area_reg;
		clear_overrun = 1'b0;
		if (opt_hit) begin
			opt_next = reg_wdata;
		end
		if (cor_hit) begin
			cor_next = reg_wdata;
		end
		if (cor_reg[`SXF_AUTO_RENEW] && host_sector_done) begin
			area_next     = host_sector_area;
			clear_overrun = 1'b1;
		end
		// software limit update, wide areas zero extended
		if (lim_hit) begin
			area_next     = AREA_W'(reg_wdata);
			clear_overrun = 1'b1;
		end
	end

	// read mux, limit reads back low eight bits only
	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`SXF_OPT_ADDR:   rdata_next = opt_reg;
				`SXF_COR_ADDR:   rdata_next = cor_reg;
				`SXF_LIMIT_ADDR: rdata_next = 8'(area_reg);
				`SXF_STAT_ADDR:  rdata_next = {5'h00, overrun, check_failure_flag,
					mode_byte_error};
				default:         rdata_next = 8'h00;
			endcase
		end
	end

	// transfer format decode
	always_comb begin
		s_blk     = opt_reg[`SXF_BLK_SEND];
		s_blk_src = opt_reg[`SXF_BLK_SEND] & opt_reg[`SXF_BLK_SRC];
		s_byt     = opt_reg[`SXF_BYT_SEND];
		s_byt_src = opt_reg[`SXF_BYT_SEND] & opt_reg[`SXF_BYT_SRC];
		s_sub     = opt_reg[`SXF_SUB_BUF];
		s_all     = opt_reg[`SXF_SUB_BUF] & opt_reg[`SXF_SUB_ALL];
		s_sts     = opt_reg[`SXF_SUB_BUF] & opt_reg[`SXF_SUB_STS];
		s_pad     = s_sts & opt_reg[`SXF_ZERO_PAD];
		if (!auto_transfer_enable) begin
			s_blk = 1'b0;
			s_byt = 1'b0;
			s_sts = 1'b0;
			s_pad = 1'b0;
		end
	end

	// correction decode, evaluated per sector
	always_comb begin
		form_next  = correction_form;
		mderr_next = mode_byte_error;
		fail_next  = check_failure_flag;
		tf_next    = 1'b0;
		ta_next    = 1'b0;
		if (sector_start) begin
			if (cor_reg[`SXF_AUTO_DISC]) begin
				if (disc_mode_byte[1:0] == 2'h1) begin
					form_next = sxf_pkg::SXF_M1;
				end else if (disc_form_bit) begin
					form_next = sxf_pkg::SXF_M2F2;
				end else begin
					form_next = sxf_pkg::SXF_M2F1;
				end
			end else if (!cor_reg[`SXF_MODE_SEL]) begin
				form_next = sxf_pkg::SXF_M1;
			end else if (cor_reg[`SXF_FORM_SEL]) begin
				form_next = sxf_pkg::SXF_M2F2;
			end else begin
				form_next = sxf_pkg::SXF_M2F1;
			end
			mderr_next = !cor_reg[`SXF_MODE_TOL] && disc_mode_byte[7:2] != 6'h00;
			fail_next = check_error;
			if (sector_is_form2 && !cor_reg[`SXF_F2_CHECK]) begin
				fail_next = 1'b0;
			end
			if (cor_reg[`SXF_AUTO_TGT] && cmd_class == sxf_pkg::SXF_CMD_AREA
				&& target_match) begin
				tf_next = 1'b1;
				ta_next = 1'b1;
			end
		end
	end

	sxf_limit_guard #(
		.AREA_W(AREA_W)
	) u_guard (
		.core_clk        (core_clk),
		.sys_rst         (sys_rst),
		.limit_enable    (cor_reg[`SXF_LIMIT_EN]),
		.cmd_class       (cmd_class),
		.clear_overrun   (clear_overrun),
		.area_done       (area_done),
		.area_done_id    (area_done_id),
		.subcode_write   (subcode_write),
		.subcode_at_limit(subcode_at_limit),
		.limit_area      (area_reg),
		.overrun_reg     (overrun)
	);

	// register file and read data
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			opt_reg   <= `SXF_OPT_RESET;
			cor_reg   <= `SXF_COR_RESET;
			area_reg  <= '0;
			reg_rdata <= 8'h00;
		end else begin
			opt_reg   <= opt_next;
			cor_reg   <= cor_next;
			area_reg  <= area_next;
			reg_rdata <= rdata_next;
		end
	end

	// transfer controls to the host side
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			send_block_flag     <= 1'b0;
			block_flag_from_cpu <= 1'b0;
			send_byte_flag      <= 1'b0;
			byte_flag_from_cpu  <= 1'b0;
			send_subcode        <= 1'b0;
			send_all_subcode    <= 1'b0;
			send_subcode_status <= 1'b0;
			send_zero_pad       <= 1'b0;
			zero_pad_count      <= 3'h0;
		end else begin
			send_block_flag     <= s_blk;
			block_flag_from_cpu <= s_blk_src;
			send_byte_flag      <= s_byt;
			byte_flag_from_cpu  <= s_byt_src;
			send_subcode        <= s_sub;
			send_all_subcode    <= s_all;
			send_subcode_status <= s_sts;
			send_zero_pad       <= s_pad;
			zero_pad_count      <= s_pad ? `SXF_PAD_COUNT : 3'h0;
		end
	end

	// correction controls, per sector
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			correction_form    <= sxf_pkg::SXF_M1;
			mode_byte_error    <= 1'b0;
			check_failure_flag <= 1'b0;
			target_found       <= 1'b0;
			target_advance     <= 1'b0;
		end else begin
			correction_form    <= form_next;
			mode_byte_error    <= mderr_next;
			check_failure_flag <= fail_next;
			target_found       <= tf_next;
			target_advance     <= ta_next;
		end
	end

	// limit status and pointer
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			drive_overrun_status <= 1'b0;
			buffer_write_block   <= 1'b0;
			drive_limit_area_ptr <= '0;
		end else begin
			drive_overrun_status <= overrun;
			buffer_write_block   <= overrun;
			drive_limit_area_ptr <= area_reg;
		end
	end
endmodule : sxf_ctl

/* File: sxf_ctl_monitor.sv */
// checker of the transfer format and correction controls
// assumes it is bound into sxf_ctl, one core_clk domain
`include "sxf_cfg.svh"
module sxf_ctl_monitor #(
	parameter int AREA_W = 9
) (
	// clock and reset
	input wire logic			core_clk,
	input wire logic			sys_rst,
	// register port
	input wire logic [`SXF_ADDR_W-1:0]	reg_addr,
	input wire logic [7:0]		reg_wdata,
	input wire logic			reg_wr,
	// context
	input wire sxf_pkg::sxf_cmd_t	cmd_class,
	input wire logic			auto_transfer_enable,
	input wire logic [7:0]		disc_mode_byte,
	input wire logic			sector_start,
	input wire logic			sector_is_form2,
	input wire logic			area_done,
	input wire logic [AREA_W-1:0]	area_done_id,
	input wire logic			subcode_write,
	input wire logic			subcode_at_limit,
	// watched outputs
	input wire logic			send_subcode_status,
	input wire logic			send_zero_pad,
	input wire logic [2:0]		zero_pad_count,
	input wire sxf_pkg::sxf_form_t	correction_form,
	input wire logic			mode_byte_error,
	input wire logic			check_failure_flag,
	input wire logic			target_found,
	input wire logic			drive_overrun_status,
	input wire logic [AREA_W-1:0]	drive_limit_area_ptr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [7:0]		cor_reg;
	logic [7:0]		cor_next;
	sxf_pkg::sxf_form_t	man_form;
	// shadow of the correction register
	always_comb begin
		cor_next = cor_reg;
		if (reg_wr && reg_addr == `SXF_COR_ADDR) begin
			cor_next = reg_wdata;
		end
		man_form = !cor_reg[6] ? sxf_pkg::SXF_M1 :
			(cor_reg[5] ? sxf_pkg::SXF_M2F2 : sxf_pkg::SXF_M2F1);
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cor_reg <= 8'h00;
		end else begin
			cor_reg <= cor_next;
		end
	end
	sequence area_hit;
		cmd_class == sxf_pkg::SXF_CMD_AREA && cor_reg[1] && area_done &&
			area_done_id == drive_limit_area_ptr;
	endsequence
	sequence sub_hit;
		cmd_class == sxf_pkg::SXF_CMD_SUBCODE && cor_reg[1] && subcode_write && subcode_at_limit;
	endsequence
	a_status_gate: assert property (reg_wr && reg_addr == `SXF_OPT_ADDR
		##1 auto_transfer_enable
		|=> send_subcode_status == (($past(reg_wdata, 2) & 8'h0A) == 8'h0A))
		else $error("status gate");
	a_pad_gate: assert property (send_zero_pad |-> send_subcode_status && zero_pad_count == 3'h5)
		else $error("pad without status");
	a_manual_form: assert property (sector_start && !cor_reg[7]
		|=> correction_form == $past(man_form)) else $error("manual form wrong");
	a_check_off: assert property (sector_start && !cor_reg[3] && sector_is_form2
		|=> !check_failure_flag) else $error("check flag not held low");
	a_mode_tol: assert property (sector_start && !cor_reg[2] && disc_mode_byte[7:2] != 6'h00
		|=> mode_byte_error) else $error("mode byte error missed");
	a_area_overrun: assert property (area_hit |-> ##2 drive_overrun_status)
		else $error("area overrun late");
	a_sub_overrun: assert property (sub_hit |-> ##2 drive_overrun_status)
		else $error("subcode overrun late");
	a_limit_off: assert property ((!cor_reg[1] && !drive_overrun_status)[*3]
		|=> !drive_overrun_status) else $error("overrun while disabled");
	a_target_cause: assert property (target_found
		|-> $past(sector_start) && ($past(cor_reg) & 8'h10) != 8'h00) else $error("stray target");
endmodule : sxf_ctl_monitor

bind sxf_ctl sxf_ctl_monitor #(.AREA_W(AREA_W)) u_mon (.core_clk, .sys_rst, .reg_addr,
	.reg_wdata, .reg_wr, .cmd_class, .auto_transfer_enable, .disc_mode_byte, .sector_start,
	.sector_is_form2, .area_done, .area_done_id, .subcode_write, .subcode_at_limit,
	.send_subcode_status, .send_zero_pad, .zero_pad_count, .correction_form, .mode_byte_error,
	.check_failure_flag, .target_found, .drive_overrun_status, .drive_limit_area_ptr);

/* File: sxf_disc_model.sv */
// disc side: one sector_start pulse per request, header fields with it
// assumes requests one cycle long; fields are garbage outside the pulse
module sxf_disc_model (
	// clock and request
	input wire logic		core_clk,
	input wire logic		req,
	input wire logic [7:0]	req_mode,
	input wire logic		req_form2,
	input wire logic		req_err,
	// sector fields
	output logic		sector_start = 1'b0,
	output logic [7:0]	disc_mode_byte = 8'h00,
	output logic		disc_form_bit = 1'b0,
	output logic		sector_is_form2 = 1'b0,
	output logic		check_error = 1'b0,
	output logic		target_match = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge core_clk) begin
		sector_start <= req;
		disc_mode_byte <= req ? req_mode : ~disc_mode_byte;
		disc_form_bit <= req ? req_form2 : ~disc_form_bit;
		sector_is_form2 <= req ? req_form2 : ~sector_is_form2;
		check_error <= req ? req_err : ~check_error;
		target_match <= req ? req_err : ~target_match;
	end
endmodule : sxf_disc_model

/* File: tb.sv */
// self-checking bench of the transfer format and correction controls
// assumes sxf_ctl with AREA_W 8 and the disc model beside it
`include "sxf_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00, req_mode = 8'h00, reg_rdata;
	logic auto_transfer_enable = 1'b1, req_form2 = 1'b0, req_err = 1'b0;
	sxf_pkg::sxf_cmd_t cmd_class = sxf_pkg::SXF_CMD_AREA;
	logic sector_start, disc_form_bit, sector_is_form2, check_error, target_match;
	logic [7:0] disc_mode_byte, drive_limit_area_ptr;
	logic area_done = 1'b0, subcode_write = 1'b0, subcode_at_limit = 1'b0, host_sector_done = 1'b0;
	logic [7:0] area_done_id = 8'h05, host_sector_area = 8'h00;
	logic send_block_flag, block_flag_from_cpu, send_byte_flag, byte_flag_from_cpu, send_subcode;
	logic send_all_subcode, send_subcode_status, send_zero_pad, mode_byte_error, check_failure_flag;
	logic target_found, target_advance, drive_overrun_status, buffer_write_block;
	logic [2:0] zero_pad_count;
	sxf_pkg::sxf_form_t correction_form;
	int num_errors = 0;
	int n_tests = 0;
	sxf_disc_model u_disc (.core_clk, .req, .req_mode, .req_form2, .req_err, .sector_start,
		.disc_mode_byte, .disc_form_bit, .sector_is_form2, .check_error, .target_match);
	sxf_ctl #(.AREA_W(8)) dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .cmd_class, .auto_transfer_enable, .disc_mode_byte, .disc_form_bit,
		.sector_start, .sector_is_form2, .check_error, .target_match, .area_done, .area_done_id,
		.subcode_write, .subcode_at_limit, .host_sector_done, .host_sector_area, .send_block_flag,
		.block_flag_from_cpu, .send_byte_flag, .byte_flag_from_cpu, .send_subcode,
		.send_all_subcode, .send_subcode_status, .send_zero_pad, .zero_pad_count,
		.correction_form, .mode_byte_error, .check_failure_flag, .target_found, .target_advance,
		.drive_overrun_status, .buffer_write_block, .drive_limit_area_ptr);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd
	task automatic sect(input logic [7:0] m, input logic f, input logic e);
		@(posedge core_clk);
		req <= 1'b1;
		req_mode <= m;
		req_form2 <= f;
		req_err <= e;
		@(posedge core_clk);
		req <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask : sect
	task automatic evt(input int k);
		@(posedge core_clk);
		area_done <= (k == 0);
		subcode_write <= (k == 1);
		host_sector_done <= (k == 2);
		@(posedge core_clk);
		area_done <= 1'b0;
		subcode_write <= 1'b0;
		host_sector_done <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : evt
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		logic [7:0] d;
		static logic [7:0] opt [7] = '{8'hFF, 8'h0B, 8'h0D, 8'h0A, 8'hA8, 8'h50, 8'h03};
		static logic [7:0] man [4] = '{8'h00, 8'h40, 8'h60, 8'h20};
		static logic [7:0] mexp [4] = '{8'h01, 8'h02, 8'h04, 8'h01};
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`SXF_OPT_ADDR, 8'h00);
		rd(`SXF_COR_ADDR, 8'h00);
		wr(5'h03, 8'hFF);
		rd(5'h03, 8'h00);
		for (int i = 0; i < 7; i++) begin
			d = opt[i];
			wr(`SXF_OPT_ADDR, d);
			chk({block_flag_from_cpu, byte_flag_from_cpu, send_block_flag, send_byte_flag,
				send_subcode, send_all_subcode, send_subcode_status, send_zero_pad},
				{d[7] & d[6], d[5] & d[4], d[7], d[5], d[3], d[3] & d[2], d[3] & d[1],
				d[3] & d[1] & d[0]});
			chk({5'h00, zero_pad_count}, (d[3] & d[1] & d[0]) ? 8'h05 : 8'h00);
			rd(`SXF_OPT_ADDR, d);
		end
		@(posedge core_clk);
		auto_transfer_enable <= 1'b0;
		wr(`SXF_OPT_ADDR, 8'hFF);
		chk({4'h0, send_block_flag, send_byte_flag, send_subcode_status, send_zero_pad},
			8'h00);
		auto_transfer_enable <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(`SXF_COR_ADDR, man[i]);
			sect(8'h02, 1'b1, 1'b0);
			chk({5'h00, correction_form}, mexp[i]);
		end
		wr(`SXF_COR_ADDR, 8'hA0);
		sect(8'h02, 1'b1, 1'b0);
		chk({5'h00, correction_form}, 8'h04);
		sect(8'h02, 1'b0, 1'b0);
		chk({5'h00, correction_form}, 8'h02);
		sect(8'h01, 1'b1, 1'b0);
		chk({5'h00, correction_form}, 8'h01);
		wr(`SXF_COR_ADDR, 8'h00);
		sect(8'h06, 1'b0, 1'b0);
		chk({7'h00, mode_byte_error}, 8'h01);
		wr(`SXF_COR_ADDR, 8'h04);
		sect(8'h06, 1'b0, 1'b0);
		chk({7'h00, mode_byte_error}, 8'h00);
		wr(`SXF_COR_ADDR, 8'h60);
		sect(8'h02, 1'b1, 1'b1);
		chk({7'h00, check_failure_flag}, 8'h00);
		wr(`SXF_COR_ADDR, 8'h68);
		sect(8'h02, 1'b1, 1'b1);
		chk({7'h00, check_failure_flag}, 8'h01);
		rd(`SXF_STAT_ADDR, 8'h02);
		wr(`SXF_COR_ADDR, 8'h10);
		sect(8'h02, 1'b1, 1'b1);
		chk({6'h00, target_found, target_advance}, 8'h03);
		@(posedge core_clk);
		#1;
		chk({6'h00, target_found, target_advance}, 8'h00);
		wr(`SXF_COR_ADDR, 8'h00);
		sect(8'h02, 1'b1, 1'b1);
		chk({6'h00, target_found, target_advance}, 8'h00);
		wr(`SXF_LIMIT_ADDR, 8'h05);
		subcode_at_limit <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			cmd_class <= k ? sxf_pkg::SXF_CMD_SUBCODE : sxf_pkg::SXF_CMD_AREA;
			for (int en = 1; en >= 0; en--) begin
				wr(`SXF_COR_ADDR, en ? 8'h02 : 8'h00);
				evt(k);
				chk({6'h00, drive_overrun_status, buffer_write_block},
					en ? 8'h03 : 8'h00);
				wr(`SXF_LIMIT_ADDR, 8'h05);
				chk({7'h00, drive_overrun_status}, 8'h00);
			end
		end
		cmd_class <= sxf_pkg::SXF_CMD_AREA;
		wr(`SXF_COR_ADDR, 8'h02);
		wr(`SXF_LIMIT_ADDR, 8'h06);
		evt(0);
		chk({6'h00, drive_overrun_status, buffer_write_block}, 8'h00);
		wr(`SXF_COR_ADDR, 8'h01);
		host_sector_area <= 8'h33;
		evt(2);
		chk(drive_limit_area_ptr, 8'h33);
		wr(`SXF_COR_ADDR, 8'h00);
		host_sector_area <= 8'h44;
		evt(2);
		chk(drive_limit_area_ptr, 8'h33);
		wr(`SXF_LIMIT_ADDR, 8'h44);
		chk(drive_limit_area_ptr, 8'h44);
		print_verdict();
	end
endmodule : tb
